//--- pkg/dbgid_defines.svh
// offsets, field positions, reset values and identity constants of the debug id window
`ifndef DBGID_DEFINES_SVH
`define DBGID_DEFINES_SVH

// device-specific registers, control upward from the base
`define DBGID_OFF_CTRL      12'h000
`define DBGID_OFF_STAT      12'h004
`define DBGID_OFF_CMD       12'h008
// integration register grows downward below the management region
`define DBGID_OFF_INTEG     12'hefc

// management region and identification words
`define DBGID_MGMT_BASE     12'hf00
`define DBGID_PID_BASE      12'hfd0
`define DBGID_OFF_PID4      12'hfd0
`define DBGID_OFF_PID5      12'hfd4
`define DBGID_OFF_PID6      12'hfd8
`define DBGID_OFF_PID7      12'hfdc
`define DBGID_OFF_PID0      12'hfe0
`define DBGID_OFF_PID1      12'hfe4
`define DBGID_OFF_PID2      12'hfe8
`define DBGID_OFF_PID3      12'hfec
`define DBGID_OFF_CID0      12'hff0
`define DBGID_OFF_CID1      12'hff4
`define DBGID_OFF_CID2      12'hff8
`define DBGID_OFF_CID3      12'hffc

// field positions
`define DBGID_CTRL_MODE_MSB 1
`define DBGID_CMD_CLR_BIT   0
`define DBGID_CMD_WCLR_BIT  1
`define DBGID_STAT_RES1_BIT 31
`define DBGID_STAT_WRAP_BIT 16
`define DBGID_CNT_W         16

// reset values
`define DBGID_CTRL_RST      2'h0
`define DBGID_INTEG_RST     1'h0
`define DBGID_MINOR_FIX_RST 4'h0

// fixed identification fields
`define DBGID_CLASS         4'h9
`define DBGID_SIZE          4'h0
`define DBGID_REVISION      4'h0
`define DBGID_CUST_MOD      4'h0
`define DBGID_JEDEC_USED    1'h1

`endif

//--- pkg/dbgid_pkg.sv
// types shared by the debug id window modules
package dbgid_pkg;

  // counter modes held in the control register
  typedef enum logic [1:0] {
    DBGID_MODE_OFF,
    DBGID_MODE_FREE,
    DBGID_MODE_EVENT,
    DBGID_MODE_RSVD
  } dbgid_mode_t;

  // bus access phase
  typedef enum logic {
    DBGID_ST_IDLE,
    DBGID_ST_RESP
  } dbgid_state_t;

endpackage

//--- rtl/dbgid_minor_fix_revision_flops.sv
// minor-fix revision held in flops so a metal fix can change it
`timescale 1ns/10ps
`include "dbgid_defines.svh"
module dbgid_minor_fix_flops (
  input  wire logic       i_clk_sys,
  input  wire logic       i_sys_rst,
  output logic      [3:0] o_minor_fix
);
  localparam logic [3:0] RST_VAL = `DBGID_MINOR_FIX_RST;

  // one flop per bit, each re-tieable on its own by an eco
  for (genvar g = 0; g < 4; g++) begin : g_bit
    always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
        o_minor_fix[g] <= RST_VAL[g]; // R20
      end else begin
        o_minor_fix[g] <= o_minor_fix[g];
      end
    end
  end
endmodule // dbgid_minor_fix_flops

//--- rtl/dbgid_id_rom.sv
// identification byte lookup for the top words of the window
`timescale 1ns/10ps
`include "dbgid_defines.svh"
module dbgid_id_rom #(
  parameter logic [11:0] P_PART_NUM = 12'h123, // arbitrary value
  parameter logic [3:0]  P_DES_CONT = 4'h0,    // arbitrary value
  parameter logic [6:0]  P_DES_ID   = 7'h15,   // arbitrary value
  parameter logic [7:0]  P_PRE0     = 8'h00,
  parameter logic [3:0]  P_PRE1     = 4'h0,
  parameter logic [7:0]  P_PRE2     = 8'h00,
  parameter logic [7:0]  P_PRE3     = 8'h00
) (
  input  wire logic [11:0] i_addr,
  input  wire logic [3:0]  i_minor_fix,
  output logic             o_hit,
  output logic      [7:0]  o_byte
);
  // word match, byte lanes ignored since only word accesses exist
  function automatic logic at(input logic [11:0] a, input logic [11:0] off);
    return a[11:2] == off[11:2];
  endfunction

  // identification bytes, bits 31:8 are left to the caller as zero
  assign o_hit  = i_addr[11:2] >= `DBGID_PID_BASE >> 2; // R10
  assign o_byte =
    at(i_addr, `DBGID_OFF_PID4) ? {`DBGID_SIZE, P_DES_CONT} :           // R12 R21
    at(i_addr, `DBGID_OFF_PID0) ? P_PART_NUM[7:0] :                     // R15
    at(i_addr, `DBGID_OFF_PID1) ? {P_DES_ID[3:0], P_PART_NUM[11:8]} :   // R15 R17
    at(i_addr, `DBGID_OFF_PID2) ? {`DBGID_REVISION, `DBGID_JEDEC_USED,
                                   P_DES_ID[6:4]} :                     // R14 R18
    at(i_addr, `DBGID_OFF_PID3) ? {i_minor_fix, `DBGID_CUST_MOD} :      // R13 R19
    at(i_addr, `DBGID_OFF_CID0) ? P_PRE0 :
    at(i_addr, `DBGID_OFF_CID1) ? {`DBGID_CLASS, P_PRE1} :              // R11
    at(i_addr, `DBGID_OFF_CID2) ? P_PRE2 :
    at(i_addr, `DBGID_OFF_CID3) ? P_PRE3 :
    8'h00; // R16
endmodule // dbgid_id_rom

//--- rtl/dbgid_window.sv
// debug component register window: device registers, management region, id words
`timescale 1ns/10ps
`include "dbgid_defines.svh"
//
// Behaviour
// R1: words 0xf00-0xffc hold only management registers, never device controls.
// R2: peripheral id at 0xfd0-0xfec, component id in last four words.
// R3: device controls grow up from 0x000, integration down from 0xefc.
// R4: all accesses are aligned 32-bit word accesses.
// R5: reading write-only or writing read-only acts as reserved: zero, no effect.
// R6: unimplemented registers and bits read zero and ignore writes.
// R7: reserved fields read fixed zero or fixed one and ignore writes.
// R8: host treats reserved bits unknown, never reads wo nor writes ro.
// R9: reserved written values map onto a permitted behaviour.
// R10: every component has both component and peripheral id sets.
// R11: component id word one class field encodes the component class.
// R12: peripheral id word four holds size count and continuation count.
// R13: peripheral id word three holds minor-fix revision and customer modified.
// R14: peripheral id word two: revision, bit 3 one, designer bits 6:4.
// R15: word one: designer bits 3:0 and part 11:8; word zero part 7:0.
// R16: peripheral id words five to seven read zero.
// R17: designer code is continuation count plus low seven bits of final byte.
// R18: revision starts at zero, one step per revision.
// R19: customer modified field reports licensee changes, normally zero.
// R20: minor-fix revision driven from flops resetting to zero.
// R21: size count is log2 of window in 4KB units, zero here.
// R22: full words present their bytes little-endian.
// R23: id words constant after reset, bits 31:8 read zero.
module dbgid_window
  import dbgid_pkg::*;
#(
  parameter logic [11:0] P_PART_NUM = 12'h123, // arbitrary value
  parameter logic [3:0]  P_DES_CONT = 4'h0,    // arbitrary value
  parameter logic [6:0]  P_DES_ID   = 7'h15    // arbitrary value
) (
  input  wire logic        i_clk_sys,
  input  wire logic        i_sys_rst,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  input  wire logic        i_event,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  output logic             o_count_active,
  output logic             o_integ_out
);

  dbgid_state_t           state;
  dbgid_state_t           next_state;
  dbgid_mode_t            mode;
  logic                   integ;
  logic [`DBGID_CNT_W-1:0] count;
  logic                   wrap;
  logic [3:0]             minor_fix;
  logic                   id_hit;
  logic [7:0]             id_byte;

  // word decode, low two address bits never matter
  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    return a[11:2] == off[11:2]; // R4
  endfunction

  // access phase is taken once, the response cycle blocks a second take
  wire acc   = i_psel & i_penable & (state == DBGID_ST_IDLE);
  wire wr_go = acc & i_pwrite;
  wire rd_go = acc & ~i_pwrite;

  // register decode
  wire hit_ctrl  = hit(i_paddr, `DBGID_OFF_CTRL);  // R3
  wire hit_stat  = hit(i_paddr, `DBGID_OFF_STAT);  // R3
  wire hit_cmd   = hit(i_paddr, `DBGID_OFF_CMD);   // R3
  wire hit_integ = hit(i_paddr, `DBGID_OFF_INTEG); // R3
  wire in_mgmt   = i_paddr >= `DBGID_MGMT_BASE;    // R1
  wire in_pid    = i_paddr >= `DBGID_PID_BASE &&
                   i_paddr[11:2] <= `DBGID_OFF_PID3 >> 2; // R2

  // counter steering; the reserved mode is kept but behaves as off
  wire mode_free  = mode == DBGID_MODE_FREE;
  wire mode_event = mode == DBGID_MODE_EVENT;
  wire count_on   = mode_free | (mode_event & i_event); // R9
  wire cnt_clr    = wr_go & hit_cmd & i_pwdata[`DBGID_CMD_CLR_BIT];
  wire wrap_clr   = wr_go & hit_cmd & i_pwdata[`DBGID_CMD_WCLR_BIT];
  wire wrap_evt   = count_on & (&count) & ~cnt_clr;
  wire [`DBGID_CNT_W-1:0] next_count =
    cnt_clr  ? '0 :
    count_on ? count + `DBGID_CNT_W'(1) : count;
  // hardware set beats a software clear in the same cycle
  wire next_wrap  = wrap_evt | (wrap & ~wrap_clr);

  // status word: bit 31 reserved-one, the rest of the spare bits zero
  wire [31:0] stat_word = {1'b1, 14'h0000, wrap, count}; // R7

  // read mux; write-only, management gaps and unmapped words read zero
  wire [31:0] rd_word =
    hit_ctrl  ? {30'h0000_0000, mode} :        // R6
    hit_stat  ? stat_word :
    hit_integ ? {31'h0000_0000, integ} :       // R6
    id_hit    ? {24'h00_0000, id_byte} :       // R23 R22
    32'h0000_0000; // R5 R6 R1

  wire [31:0] next_prdata = rd_go ? rd_word : 32'h0000_0000;

  // one wait state: response follows the access phase by one edge
  assign next_state = acc ? DBGID_ST_RESP : DBGID_ST_IDLE; // R4

  // identification bytes
  dbgid_id_rom #(
    .P_PART_NUM (P_PART_NUM),
    .P_DES_CONT (P_DES_CONT),
    .P_DES_ID   (P_DES_ID)
  ) u_id_rom (
    .i_addr      (i_paddr),
    .i_minor_fix (minor_fix),
    .o_hit       (id_hit),
    .o_byte      (id_byte)
  );

  // minor-fix revision flops
  dbgid_minor_fix_flops u_minor_fix (
    .i_clk_sys   (i_clk_sys),
    .i_sys_rst   (i_sys_rst),
    .o_minor_fix (minor_fix)
  );

  // bus response
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      state     <= DBGID_ST_IDLE;
      o_pready  <= 1'b0;
      o_prdata  <= 32'h0000_0000;
      o_pslverr <= 1'b0;
    end else begin
      state     <= next_state;
      o_pready  <= acc;
      o_prdata  <= next_prdata;
      o_pslverr <= 1'b0; // no error: reserved words are raz/wi, not faults
    end
  end

  // writable registers; command writes act in the counter block, writes elsewhere fall on nothing
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      mode  <= dbgid_mode_t'(`DBGID_CTRL_RST);
      integ <= `DBGID_INTEG_RST;
    end else begin
      if (wr_go & hit_ctrl) begin
        mode <= dbgid_mode_t'(i_pwdata[`DBGID_CTRL_MODE_MSB:0]); // R9
      end
      if (wr_go & hit_integ) begin
        integ <= i_pwdata[0]; // R3
      end
    end
  end

  // event counter and sticky wrap flag
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      count          <= '0;
      wrap           <= 1'b0;
      o_count_active <= 1'b0;
      o_integ_out    <= `DBGID_INTEG_RST;
    end else begin
      count          <= next_count;
      wrap           <= next_wrap;
      o_count_active <= count_on;
      o_integ_out    <= integ;
    end
  end

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);

  property p_mgmt_raz;
    rd_go && in_mgmt && !in_pid && !id_hit |=> o_prdata == 32'h0000_0000;
  endproperty
  a_mgmt_raz: assert property (p_mgmt_raz) // R1
    else $error("management gap did not read zero");

  property p_jedec_bit;
    rd_go && hit(i_paddr, `DBGID_OFF_PID2) |=> o_prdata[3] && o_pready;
  endproperty
  a_jedec_bit: assert property (p_jedec_bit) // R14
    else $error("peripheral id word two bit 3 not set");

  property p_ready_once;
    acc |=> o_pready ##1 !o_pready;
  endproperty
  a_ready_once: assert property (p_ready_once) // R4
    else $error("ready not a single cycle after access");

  property p_wo_raz;
    rd_go && hit_cmd |=> o_prdata == 32'h0000_0000;
  endproperty
  a_wo_raz: assert property (p_wo_raz) // R5
    else $error("write-only register did not read zero");

  property p_ro_wi;
    wr_go && !hit_ctrl |=> mode == $past(mode);
  endproperty
  a_ro_wi: assert property (p_ro_wi) // R6
    else $error("control changed on a write elsewhere");

  property p_res1;
    rd_go && hit_stat |=> o_prdata[`DBGID_STAT_RES1_BIT] && o_prdata[30:17] == 14'h0000;
  endproperty
  a_res1: assert property (p_res1) // R7
    else $error("status reserved fields wrong");

  property p_rsvd_mode;
    mode == DBGID_MODE_RSVD |=> !o_count_active;
  endproperty
  a_rsvd_mode: assert property (p_rsvd_mode) // R9
    else $error("reserved mode counted");

  property p_class;
    rd_go && hit(i_paddr, `DBGID_OFF_CID1) |=> o_prdata[7:4] == `DBGID_CLASS;
  endproperty
  a_class: assert property (p_class) // R11
    else $error("component class wrong");

  property p_size;
    rd_go && hit(i_paddr, `DBGID_OFF_PID4) |=> o_prdata[7:0] == {`DBGID_SIZE, P_DES_CONT};
  endproperty
  a_size: assert property (p_size) // R21
    else $error("size or continuation count wrong");

  property p_pid_rsvd;
    rd_go && i_paddr[11:2] inside {10'h3f5, 10'h3f6, 10'h3f7} |=> o_prdata == 32'h0;
  endproperty
  a_pid_rsvd: assert property (p_pid_rsvd) // R16
    else $error("reserved peripheral id word not zero");

  property p_id_upper;
    rd_go && id_hit |=> o_prdata[31:8] == 24'h00_0000 ##1 o_prdata == 32'h0;
  endproperty
  a_id_upper: assert property (p_id_upper) // R23
    else $error("id word upper bits not zero");

  property p_wrap_wins;
    wrap_evt && wrap_clr |=> wrap;
  endproperty
  a_wrap_wins: assert property (p_wrap_wins) // R6
    else $error("wrap lost against clear");

  property p_minor_fix_zero;
    rd_go && hit(i_paddr, `DBGID_OFF_PID3) |=> o_prdata[7:4] == `DBGID_MINOR_FIX_RST;
  endproperty
  a_minor_fix_zero: assert property (p_minor_fix_zero) // R20
    else $error("minor-fix revision not at reset value");

  // id words field by field, against parameters and fixed fields
  property p_pid_region;
    i_psel |-> id_hit == (i_paddr[11:2] >= 10'h3f4);
  endproperty
  a_pid_region: assert property (p_pid_region) // R2
    else $error("id decode outside the top words");

  property p_part_low;
    rd_go && hit(i_paddr, `DBGID_OFF_PID0) |=> o_prdata == {24'h00_0000, P_PART_NUM[7:0]};
  endproperty
  a_part_low: assert property (p_part_low) // R15
    else $error("part number low byte wrong");

  property p_part_des;
    rd_go && hit(i_paddr, `DBGID_OFF_PID1) |=>
      o_prdata[7:0] == {P_DES_ID[3:0], P_PART_NUM[11:8]};
  endproperty
  a_part_des: assert property (p_part_des) // R15
    else $error("designer low bits or part high bits wrong");

  property p_rev_des;
    rd_go && hit(i_paddr, `DBGID_OFF_PID2) |=>
      o_prdata[7:4] == `DBGID_REVISION && o_prdata[2:0] == P_DES_ID[6:4];
  endproperty
  a_rev_des: assert property (p_rev_des) // R18
    else $error("revision or designer high bits wrong");

  property p_cust_mod;
    rd_go && hit(i_paddr, `DBGID_OFF_PID3) |=> o_prdata[3:0] == `DBGID_CUST_MOD;
  endproperty
  a_cust_mod: assert property (p_cust_mod) // R19
    else $error("customer modified field wrong");

  property p_des_cont;
    rd_go && hit(i_paddr, `DBGID_OFF_PID4) |=> o_prdata[3:0] == P_DES_CONT;
  endproperty
  a_des_cont: assert property (p_des_cont) // R12
    else $error("continuation count wrong");

  property p_preamble;
    rd_go && i_paddr[11:2] inside {10'h3fc, 10'h3fe, 10'h3ff} |=> o_prdata == 32'h0;
  endproperty
  a_preamble: assert property (p_preamble) // R10
    else $error("component id preamble word not zero");

  // bus answer shape: one clean pulse, zero data outside it
  property p_no_err;
    o_pslverr == 1'b0;
  endproperty
  a_no_err: assert property (p_no_err) // R5
    else $error("error response raised");

  property p_idle_zero;
    !o_pready |-> o_prdata == 32'h0000_0000;
  endproperty
  a_idle_zero: assert property (p_idle_zero) // R6
    else $error("read data outside the response cycle");

  property p_wr_zero;
    wr_go |=> o_prdata == 32'h0000_0000;
  endproperty
  a_wr_zero: assert property (p_wr_zero) // R5
    else $error("write answered with read data");

  property p_ready_idle;
    !acc |=> !o_pready;
  endproperty
  a_ready_idle: assert property (p_ready_idle) // R4
    else $error("ready without a taken access");

  property p_ctrl_raz;
    rd_go && hit_ctrl |=> o_prdata[31:2] == 30'h0000_0000;
  endproperty
  a_ctrl_raz: assert property (p_ctrl_raz) // R6
    else $error("control spare bits not zero");

  property p_integ_raz;
    rd_go && hit_integ |=> o_prdata[31:1] == 31'h0000_0000;
  endproperty
  a_integ_raz: assert property (p_integ_raz) // R6
    else $error("integration spare bits not zero");

  // writable state follows the bus
  property p_mode_wr;
    wr_go && hit_ctrl |=> mode == $past(i_pwdata[`DBGID_CTRL_MODE_MSB:0]);
  endproperty
  a_mode_wr: assert property (p_mode_wr) // R9
    else $error("mode not stored as written");

  property p_count_clr;
    cnt_clr |=> count == '0;
  endproperty
  a_count_clr: assert property (p_count_clr) // R3
    else $error("counter not cleared by command");

  c_read_class: cover property (rd_go && hit(i_paddr, `DBGID_OFF_CID1));
  c_write_ctrl: cover property (wr_go && hit_ctrl ##2 o_count_active);
  c_wrap:       cover property (wrap_evt);
  c_ro_write:   cover property (wr_go && id_hit);
  c_wrap_clash: cover property (wrap_evt && wrap_clr);

endmodule // dbgid_window

//--- tb/dbgid_host_model.sv
// bus host model issuing apb style word accesses into the id window
`timescale 1ns/10ps
module dbgid_host_model (
  input  wire logic        i_clk_sys,
  input  wire logic        i_pready,
  output logic             o_psel,
  output logic             o_penable,
  output logic             o_pwrite,
  output logic      [11:0] o_paddr,
  output logic      [31:0] o_pwdata
);
  // bus idle from time zero
  initial begin
    o_psel    = 1'b0;
    o_penable = 1'b0;
    o_pwrite  = 1'b0;
    o_paddr   = 12'h000;
    o_pwdata  = 32'h0000_0000;
  end

  // setup, access, then hold until pready is sampled high or 8 rising edges pass
  task automatic xfer(input logic wr, input logic [11:0] addr, input logic [31:0] data);
    int n;
    @(negedge i_clk_sys);
    o_psel   = 1'b1;
    o_pwrite = wr;
    o_paddr  = {addr[11:2], 2'b00};
    o_pwdata = data;
    @(negedge i_clk_sys);
    o_penable = 1'b1;
    n = 0;
    do begin
      @(posedge i_clk_sys);
      n++;
    end while (i_pready !== 1'b1 && n < 8);
    @(negedge i_clk_sys);
    // released lines flip so a stale value never looks valid
    o_psel    = 1'b0;
    o_penable = 1'b0;
    o_paddr   = ~o_paddr;
    o_pwdata  = ~o_pwdata;
  endtask
endmodule // dbgid_host_model

//--- tb/tb_top.sv
// self-checking bench for the debug id window
`timescale 1ns/10ps
`include "dbgid_defines.svh"
module tb_top;
  localparam logic [11:0] P_PART = 12'h2a7; // arbitrary value
  localparam logic [3:0]  P_CONT = 4'h3;    // arbitrary value
  localparam logic [6:0]  P_ID   = 7'h5c;   // arbitrary value

  logic        i_clk_sys;
  logic        i_sys_rst;
  logic        i_psel;
  logic        i_penable;
  logic        i_pwrite;
  logic [11:0] i_paddr;
  logic [31:0] i_pwdata;
  logic        i_event;
  logic [31:0] o_prdata;
  logic        o_pready;
  logic        o_pslverr;
  logic        o_count_active;
  logic        o_integ_out;
  logic [31:0] exp_q[$];
  logic [7:0]  idb[12];
  logic [11:0] a;
  logic [31:0] d;
  int          failures = 0;
  int          compares = 0;

  dbgid_window #(.P_PART_NUM(P_PART), .P_DES_CONT(P_CONT), .P_DES_ID(P_ID)) DUT (
    .i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
    .i_pwdata(i_pwdata), .i_event(i_event), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr),
    .o_count_active(o_count_active), .o_integ_out(o_integ_out));

  dbgid_host_model host (
    .i_clk_sys(i_clk_sys), .i_pready(o_pready), .o_psel(i_psel),
    .o_penable(i_penable), .o_pwrite(i_pwrite), .o_paddr(i_paddr),
    .o_pwdata(i_pwdata));

  // 40 mhz clock
  always #12.5 i_clk_sys = ~i_clk_sys;

  // bus words: read data
  task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // single pin levels
  task automatic chk_bit(input string what, input logic exp, input logic got);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %b seen %b", what, exp, got);
    end
  endtask

  // note the expected read data first, then run the access
  task automatic rd(input logic [11:0] ad, input logic [31:0] e);
    exp_q.push_back(e);
    host.xfer(1'b0, ad, 32'h0000_0000);
  endtask

  // writes answer with zero read data
  task automatic wr(input logic [11:0] ad, input logic [31:0] dt);
    exp_q.push_back(32'h0000_0000);
    host.xfer(1'b1, ad, dt);
  endtask

  task automatic wrap_up;
    if (exp_q.size() != 0) failures++;
    if (failures == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // response monitor: every pready retires the oldest note
  always @(posedge i_clk_sys) begin
    if (o_pready === 1'b1) begin
      chk_bit("pslverr", 1'b0, o_pslverr);
      if (exp_q.size() == 0) chk_bit("spare pready", 1'b0, o_pready);
      else chk_word("prdata", exp_q.pop_front(), o_prdata);
    end
  end

  // watchdog: the wrap scenario needs about 66000 cycles, the rest a few hundred
  initial begin
    #(25ns * 90000);
    failures++;
    wrap_up();
  end

  initial begin
    i_clk_sys = 1'b0;
    i_sys_rst = 1'b1;
    i_event   = 1'b0;
    void'($urandom(32'h38803da0));
    idb = '{{4'h0, P_CONT}, 8'h00, 8'h00, 8'h00, P_PART[7:0], {P_ID[3:0], P_PART[11:8]},
            {4'h0, 1'b1, P_ID[6:4]}, 8'h00, 8'h00, 8'h90, 8'h00, 8'h00};
    repeat (12) @(negedge i_clk_sys);
    i_sys_rst = 1'b0;
    // id words, second pass after a write attempt on each
    for (int p = 0; p < 2; p++) begin
      for (int k = 0; k < 12; k++) begin
        a = 12'hfd0 + 12'(4 * k);
        rd(a, {24'h0, idb[k]});
        if (p == 0) wr(a, $urandom());
      end
    end
    // management gap and free device space read zero, ignore writes
    repeat (16) begin
      a = 12'hf00 + 12'(4 * ($urandom() % 52));
      wr(a, $urandom());
      rd(a, 32'h0000_0000);
      a = 12'h00c + 12'(4 * ($urandom() % 956));
      wr(a, $urandom());
      rd(a, 32'h0000_0000);
    end
    // every mode, junk in unimplemented bits; mode 3 kept but idle
    for (int m = 0; m < 4; m++) begin
      d = ($urandom() & 32'hffff_fffc) | 32'(m);
      wr(`DBGID_OFF_CTRL, d);
      rd(`DBGID_OFF_CTRL, {30'h0, d[1:0]});
    end
    wr(`DBGID_OFF_CMD, 32'h0000_0003);
    rd(`DBGID_OFF_STAT, 32'h8000_0000);
    rd(`DBGID_OFF_CMD, 32'h0000_0000);
    wr(`DBGID_OFF_STAT, $urandom());
    rd(`DBGID_OFF_STAT, 32'h8000_0000);
    // event mode counts only with the event input high
    wr(`DBGID_OFF_CTRL, 32'h0000_0002);
    rd(`DBGID_OFF_STAT, 32'h8000_0000);
    chk_bit("count_active", 1'b0, o_count_active);
    i_event = 1'b1;
    repeat (3) @(negedge i_clk_sys);
    chk_bit("count_active", 1'b1, o_count_active);
    i_event = 1'b0;
    rd(`DBGID_OFF_STAT, 32'h8000_0003);
    wr(`DBGID_OFF_CTRL, 32'h0000_0000);
    // integration bit reaches its pin, reserved bits written as read
    for (int b = 1; b >= 0; b--) begin
      wr(`DBGID_OFF_INTEG, 32'(b));
      rd(`DBGID_OFF_INTEG, 32'(b));
      chk_bit("integ_out", b[0], o_integ_out);
    end
    // count to the top, then wrap set and wrap clear meet in one cycle
    wr(`DBGID_OFF_CMD, 32'h0000_0001);
    wr(`DBGID_OFF_CTRL, 32'h0000_0002);
    i_event = 1'b1;
    repeat (65535) @(negedge i_clk_sys);
    i_event = 1'b0;
    rd(`DBGID_OFF_STAT, 32'h8000_ffff);
    // event raised in the access cycle of the clear
    fork
      wr(`DBGID_OFF_CMD, 32'h0000_0002);
      begin
        repeat (2) @(negedge i_clk_sys);
        i_event = 1'b1;
        @(negedge i_clk_sys);
        i_event = 1'b0;
      end
    join
    rd(`DBGID_OFF_STAT, 32'h8001_0000);
    wr(`DBGID_OFF_CMD, 32'h0000_0002);
    rd(`DBGID_OFF_STAT, 32'h8000_0000);
    // reset in mid-run: registers back to reset values, id words unchanged
    wr(`DBGID_OFF_INTEG, 32'h0000_0001);
    wr(`DBGID_OFF_CTRL, 32'h0000_0001);
    i_sys_rst = 1'b1;
    repeat (2) @(negedge i_clk_sys);
    i_sys_rst = 1'b0;
    chk_bit("integ_out", 1'b0, o_integ_out);
    chk_bit("count_active", 1'b0, o_count_active);
    rd(`DBGID_OFF_CTRL, 32'h0000_0000);
    rd(`DBGID_OFF_STAT, 32'h8000_0000);
    rd(`DBGID_OFF_INTEG, 32'h0000_0000);
    rd(`DBGID_OFF_PID2, {24'h0, idb[6]});
    wrap_up();
  end
endmodule // tb_top
